// File: rtl/cfc_core.sv
// Control, mode handshake and bit-timing registers of the CAN FD controller.
// Assumes the host port gives one-cycle word strobes; protocol engine status is asynchronous.
`timescale 1ns/1ps
module cfc_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [1:0] regIndex,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // Protocol engine status
  input wire logic frameActive,
  input wire logic systemError,
  input wire logic txAbortDone,
  input wire logic wakeRequest,
  // Configuration outputs
  output cfc_pkg::cfc_options_t options,
  output cfc_pkg::cfc_nominal_t nominalTiming,
  output cfc_pkg::cfc_data_t dataTiming,
  output cfc_pkg::cfc_delay_t delayComp,
  output logic abortAllTx,
  output logic oscDisable,
  output logic [2:0] currentMode,
  output logic busy,
  // Quantum pulses
  output logic nominalQuantum,
  output logic nominalBit,
  output logic dataQuantum,
  output logic dataBit,
  // Frame-level decisions
  input wire logic msgEsi,
  input wire logic errorPassive,
  input wire logic msgRateSwitch,
  input wire logic fdfRecessive,
  input wire logic resRecessive,
  output logic esiRecessive,
  output logic doRateSwitch,
  output logic formError,
  output logic busIntegrate,
  output logic [15:0] crcInitVector,
  output logic stuffCountInCrc
);
  logic [31:0] control_q;
  logic [31:0] nominal_q;
  logic [31:0] data_q;
  logic [31:0] tdc_q;
  logic [2:0] mode_q;
  logic sleep_q;
  logic frameSync1_q;
  logic frameSync2_q;
  logic sysErrSync1_q;
  logic sysErrSync2_q;
  logic abortSync1_q;
  logic abortSync2_q;
  logic wakeSync1_q;
  logic wakeSync2_q;
  logic inConfig;
  logic writeControl;
  logic [2:0] requested;
  logic [31:0] control_d;
  // Status from the protocol side is treated as asynchronous
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frameSync1_q <= 1'b0;
      frameSync2_q <= 1'b0;
      sysErrSync1_q <= 1'b0;
      sysErrSync2_q <= 1'b0;
      abortSync1_q <= 1'b0;
      abortSync2_q <= 1'b0;
      wakeSync1_q <= 1'b0;
      wakeSync2_q <= 1'b0;
    end else begin
      frameSync1_q <= frameActive;
      frameSync2_q <= frameSync1_q;
      sysErrSync1_q <= systemError;
      sysErrSync2_q <= sysErrSync1_q;
      abortSync1_q <= txAbortDone;
      abortSync2_q <= abortSync1_q;
      wakeSync1_q <= wakeRequest;
      wakeSync2_q <= wakeSync1_q;
    end
  end
  assign inConfig = (mode_q == cfc_pkg::MODE_CONFIG) && !sleep_q;
  assign writeControl = regWrite && (regIndex == cfc_pkg::REG_CONTROL);
  assign requested = control_q[cfc_pkg::REQ_LSB +: 3];
  always_comb begin
    control_d = control_q;
    if (writeControl) begin
      control_d = (control_q & ~cfc_pkg::CONTROL_FREE_MASK) |
                  (regWdata & cfc_pkg::CONTROL_FREE_MASK);
      if (inConfig) begin
        control_d = (control_d & ~cfc_pkg::CONTROL_CFG_MASK) |
                    (regWdata & cfc_pkg::CONTROL_CFG_MASK);
      end
    end
    if (abortSync2_q && control_q[cfc_pkg::ABORT_BIT]) begin
      control_d[cfc_pkg::ABORT_BIT] = 1'b0;
    end
    // The hardware clear wins over a write of one to a set flag in the same cycle
    if (writeControl && regWdata[cfc_pkg::ABORT_BIT] && !control_q[cfc_pkg::ABORT_BIT]) begin
      control_d[cfc_pkg::ABORT_BIT] = 1'b1;
    end
    if (sysErrSync2_q && !inConfig && !sleep_q) begin
      control_d[cfc_pkg::REQ_LSB +: 3] = control_q[cfc_pkg::FALLBACK_BIT] ?
          cfc_pkg::MODE_LISTEN : cfc_pkg::MODE_RESTRICTED;
    end
    // Wake from sleep returns to configuration
    if (sleep_q && wakeSync2_q) begin
      control_d[cfc_pkg::REQ_LSB +: 3] = cfc_pkg::MODE_CONFIG;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_q <= cfc_pkg::CONTROL_RESET;
    end else begin
      control_q <= control_d;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      nominal_q <= cfc_pkg::NOMINAL_RESET;
    end else if (regWrite && regIndex == cfc_pkg::REG_NOMINAL && inConfig) begin
      nominal_q <= regWdata & cfc_pkg::NOMINAL_MASK;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_q <= cfc_pkg::DATA_RESET;
    end else if (regWrite && regIndex == cfc_pkg::REG_DATA && inConfig) begin
      data_q <= regWdata & cfc_pkg::DATA_MASK;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tdc_q <= cfc_pkg::TDC_RESET;
    end else if (regWrite && regIndex == cfc_pkg::REG_TDC && inConfig) begin
      tdc_q <= regWdata & cfc_pkg::TDC_MASK;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= cfc_pkg::MODE_CONFIG;
      sleep_q <= 1'b0;
    end else if (!frameSync2_q && requested != mode_q && !(sleep_q && !wakeSync2_q)) begin
      if (requested == cfc_pkg::MODE_SLEEP) begin
        sleep_q <= 1'b1;
        mode_q <= cfc_pkg::MODE_CONFIG;
      end else begin
        sleep_q <= 1'b0;
        mode_q <= requested;
      end
    end else if (sleep_q && wakeSync2_q) begin
      sleep_q <= 1'b0;
    end
  end
  assign currentMode = mode_q;
  assign oscDisable = sleep_q;
  assign busy = frameSync2_q && !inConfig && !sleep_q;
  assign abortAllTx = control_q[cfc_pkg::ABORT_BIT];
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      unique case (regIndex)
        cfc_pkg::REG_CONTROL: begin
          regRdata <= {control_q[31:24], currentMode, control_q[20:12], busy,
                       control_q[10:0]};
        end
        cfc_pkg::REG_NOMINAL: regRdata <= nominal_q;
        cfc_pkg::REG_DATA: regRdata <= data_q;
        cfc_pkg::REG_TDC: regRdata <= tdc_q;
      endcase
    end
  end
  always_comb begin
    options.txQueueEnable = control_q[cfc_pkg::QUEUE_BIT];
    options.storeTxEvents = control_q[cfc_pkg::STORE_BIT];
    options.syserrFallbackSelect = control_q[cfc_pkg::FALLBACK_BIT];
    options.gatewayEsiMode = control_q[cfc_pkg::GATEWAY_BIT];
    options.retxLimitEnable = control_q[cfc_pkg::RETX_BIT];
    options.rateSwitchDisable = control_q[cfc_pkg::RATE_BIT];
    options.wakeFilterEnable = control_q[cfc_pkg::WAKE_EN_BIT];
    options.wakeFilterTime = control_q[cfc_pkg::WAKE_T_LSB +: 2];
    options.protoExceptionDisable = control_q[cfc_pkg::PXE_BIT];
    options.isoCrcEnable = control_q[cfc_pkg::ISO_BIT];
    options.dataFilterEnable = control_q[4:0] != 5'h00;
    options.dataFilterBitCount = (control_q[4:0] > cfc_pkg::FILTER_COUNT_MAX) ?
        cfc_pkg::FILTER_COUNT_MAX : control_q[4:0];
    options.extraIdBitEnable = tdc_q[cfc_pkg::EXTRA_ID_BIT];
    options.edgeFilterEnable = tdc_q[cfc_pkg::EDGE_BIT];
  end
  assign nominalTiming = {nominal_q[31:16], nominal_q[14:8], nominal_q[6:0]};
  assign dataTiming = {data_q[31:24], data_q[20:16], data_q[11:8], data_q[3:0]};
  // compensation mode, reserved code 3 passed through unchanged
  assign delayComp = {tdc_q[17:16], tdc_q[14:8], tdc_q[5:0]};
  assign esiRecessive = options.gatewayEsiMode ? (msgEsi || errorPassive) : errorPassive;
  assign doRateSwitch = msgRateSwitch && !options.rateSwitchDisable;
  assign formError = fdfRecessive && resRecessive && options.protoExceptionDisable;
  assign busIntegrate = fdfRecessive && resRecessive && !options.protoExceptionDisable;
  // CRC vector and stuff count; non-zero vector is the top bit
  assign crcInitVector = options.isoCrcEnable ? 16'h8000 : 16'h0000;
  assign stuffCountInCrc = options.isoCrcEnable;
  // nominal bit length is one sync plus segments
  cfc_quantum #(.PW(8), .SW(9)) nominalTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(!inConfig && !sleep_q),
    .prescaler(nominalTiming.prescaler),
    .bitQuanta(10'(nominalTiming.segOne) + 10'(nominalTiming.segTwo) + 10'h003),
    .quantumTick(nominalQuantum),
    .bitTick(nominalBit)
  );
  cfc_quantum #(.PW(8), .SW(6)) dataTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(!inConfig && !sleep_q),
    .prescaler(dataTiming.prescaler),
    .bitQuanta(7'(dataTiming.segOne) + 7'(dataTiming.segTwo) + 7'h03),
    .quantumTick(dataQuantum),
    .bitTick(dataBit)
  );
endmodule : cfc_core

// File: rtl/cfc_pkg.sv
// Package for the CAN FD control and bit-timing block.
// Assumes one system clock and a word-wide register port from the host interface.
// Contract
// - Requested-mode field selects eight target modes
// - Current-mode field reports mode, resets configuration
// - Sleep reads configuration mode, oscillator disabled
// - Feature options writable only in configuration; rate-switch disable and wake filter time stay writable in any mode
// - Transmit queue enable reserves queue RAM
// - Store-events bit records transmitted messages
// - System error falls back per select
// - Gateway bit sends error indicator recessive
// - Retransmission limit bit honours attempt counts
// - Rate-switch disable suppresses data-phase switching
// - Activity flag reads one while busy
// - Wake filter enable and time select
// - Protocol exception: form error or integrating
// - ISO CRC bit selects stuff count, vector
// - Data filter bit count, codes above 18 invalid
// - Prescaler gives quantum of code plus one
// - Nominal segment lengths are code plus one
// - Data-phase segment lengths are code plus one
// - Delay compensation mode selects auto, manual, off
// - Signed offset, six-bit compensation value
// - Twelve-bit identifier enable uses reserved bit
package cfc_pkg;
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_NOMINAL = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_TDC = 2'h3;
  localparam logic [31:0] CONTROL_RESET = 32'h0498_0760;
  localparam logic [31:0] NOMINAL_RESET = 32'h003E_0F0F;
  localparam logic [31:0] DATA_RESET = 32'h000E_0303;
  localparam logic [31:0] TDC_RESET = 32'h0002_1000;
  // Writable bits in any mode versus only in configuration mode
  localparam logic [31:0] CONTROL_FREE_MASK = 32'hFF00_1600;
  localparam logic [31:0] CONTROL_CFG_MASK = 32'h001F_017F;
  localparam logic [31:0] NOMINAL_MASK = 32'hFFFF_7F7F;
  localparam logic [31:0] DATA_MASK = 32'hFF1F_0F0F;
  localparam logic [31:0] TDC_MASK = 32'h0303_7F3F;
  localparam int ABORT_BIT = 27;
  localparam int REQ_LSB = 24;
  localparam int CUR_LSB = 21;
  localparam int BUSY_BIT = 11;
  localparam logic [4:0] FILTER_COUNT_MAX = 5'h12;
  localparam int QUEUE_BIT = 20;
  localparam int STORE_BIT = 19;
  localparam int FALLBACK_BIT = 18;
  localparam int GATEWAY_BIT = 17;
  localparam int RETX_BIT = 16;
  localparam int RATE_BIT = 12;
  localparam int WAKE_EN_BIT = 8;
  localparam int WAKE_T_LSB = 9;
  localparam int PXE_BIT = 6;
  localparam int ISO_BIT = 5;
  localparam int EXTRA_ID_BIT = 24;
  localparam int EDGE_BIT = 25;
  typedef enum logic [2:0] {
    MODE_NORMAL_FD = 3'h0,
    MODE_SLEEP = 3'h1,
    MODE_INT_LOOP = 3'h2,
    MODE_LISTEN = 3'h3,
    MODE_CONFIG = 3'h4,
    MODE_EXT_LOOP = 3'h5,
    MODE_CLASSIC = 3'h6,
    MODE_RESTRICTED = 3'h7
  } cfc_mode_t;
  typedef enum logic [1:0] {
    TDC_OFF = 2'h0,
    TDC_MANUAL = 2'h1,
    TDC_AUTO = 2'h2
  } cfc_tdc_t;
  typedef struct packed {
    logic [7:0] prescaler;
    logic [7:0] segOne;
    logic [6:0] segTwo;
    logic [6:0] jumpWidth;
  } cfc_nominal_t;
  typedef struct packed {
    logic [7:0] prescaler;
    logic [4:0] segOne;
    logic [3:0] segTwo;
    logic [3:0] jumpWidth;
  } cfc_data_t;
  typedef struct packed {
    logic txQueueEnable;
    logic storeTxEvents;
    logic syserrFallbackSelect;
    logic gatewayEsiMode;
    logic retxLimitEnable;
    logic rateSwitchDisable;
    logic wakeFilterEnable;
    logic [1:0] wakeFilterTime;
    logic protoExceptionDisable;
    logic isoCrcEnable;
    logic dataFilterEnable;
    logic [4:0] dataFilterBitCount;
    logic extraIdBitEnable;
    logic edgeFilterEnable;
  } cfc_options_t;
  typedef struct packed {
    logic [1:0] mode;
    logic signed [6:0] offset;
    logic [5:0] value;
  } cfc_delay_t;
endpackage : cfc_pkg

// File: rtl/cfc_quantum.sv
// Time-quantum and bit-length counter for one phase.
// Assumes the caller holds the lengths steady while enabled.
`timescale 1ns/1ps
module cfc_quantum #(
  parameter int PW = 8,
  parameter int SW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire logic enable,
  input wire logic [PW-1:0] prescaler,
  input wire logic [SW:0] bitQuanta,
  // Timing pulses
  output logic quantumTick,
  output logic bitTick
);
  logic [PW-1:0] preCnt_q;
  logic [SW:0] qCnt_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || !enable) begin
      preCnt_q <= '0;
    end else if (preCnt_q == prescaler) begin
      preCnt_q <= '0;
    end else begin
      preCnt_q <= preCnt_q + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || !enable) begin
      qCnt_q <= '0;
    end else if (preCnt_q == prescaler) begin
      qCnt_q <= (qCnt_q == bitQuanta - 1'b1) ? '0 : qCnt_q + 1'b1;
    end
  end
  assign quantumTick = enable && (preCnt_q == prescaler);
  assign bitTick = quantumTick && (qCnt_q == bitQuanta - 1'b1);
endmodule : cfc_quantum

// File: test/cfc_core_props.sv
// Checker for the control and bit-timing core.
// Assumes it is bound to cfc_core and sees only its ports.
`timescale 1ns/1ps
module cfc_core_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register and engine inputs
  input wire logic regWrite,
  input wire logic [1:0] regIndex,
  input wire logic [31:0] regWdata,
  input wire logic frameActive,
  input wire logic systemError,
  input wire logic txAbortDone,
  input wire logic msgEsi,
  input wire logic errorPassive,
  input wire logic msgRateSwitch,
  input wire logic fdfRecessive,
  input wire logic resRecessive,
  // Core outputs
  input wire cfc_pkg::cfc_options_t options,
  input wire logic abortAllTx,
  input wire logic oscDisable,
  input wire logic [2:0] currentMode,
  input wire logic busy,
  input wire logic esiRecessive,
  input wire logic doRateSwitch,
  input wire logic formError,
  input wire logic busIntegrate,
  input wire logic [15:0] crcInitVector,
  input wire logic stuffCountInCrc
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_sleep_config: assert property (oscDisable |-> currentMode == 3'h4)
    else $error("sleep hides config mode");
  // Rate-switch disable and wake filter time stay writable in every mode
  a_option_lock: assert property (regWrite && regIndex == 2'h0 && currentMode != 3'h4
    |=> (options & 19'h7D3FF) == ($past(options) & 19'h7D3FF))
    else $error("option changed outside config");
  a_abort_clear: assert property ($rose(txAbortDone) |-> ##[2:5] !abortAllTx)
    else $error("abort flag not cleared");
  a_esi_gateway: assert property (options.gatewayEsiMode |->
    esiRecessive == (msgEsi || errorPassive)) else $error("gateway esi wrong");
  a_rate_gate: assert property (doRateSwitch == (msgRateSwitch &&
    !options.rateSwitchDisable)) else $error("rate switch wrong");
  a_idle_busy: assert property ((!frameActive)[*5] |=> !busy)
    else $error("busy while idle");
  a_proto_exc: assert property (fdfRecessive && resRecessive |->
    formError == options.protoExceptionDisable && busIntegrate != formError)
    else $error("protocol exception wrong");
  a_iso_crc: assert property (stuffCountInCrc == options.isoCrcEnable &&
    crcInitVector == (options.isoCrcEnable ? 16'h8000 : 16'h0000)) else $error("crc mode wrong");
  a_mode_follow: assert property ((!frameActive && !systemError)[*3] ##0
    (regWrite && regIndex == 2'h0 && regWdata[26:24] == 3'h0) |-> ##[1:3] currentMode == 3'h0)
    else $error("mode request ignored");
endmodule : cfc_core_props
bind cfc_core cfc_core_props u_props (
  .mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regIndex(regIndex),
  .regWdata(regWdata), .frameActive(frameActive), .systemError(systemError),
  .txAbortDone(txAbortDone), .msgEsi(msgEsi), .errorPassive(errorPassive),
  .msgRateSwitch(msgRateSwitch), .fdfRecessive(fdfRecessive), .resRecessive(resRecessive),
  .options(options), .abortAllTx(abortAllTx), .oscDisable(oscDisable),
  .currentMode(currentMode), .busy(busy), .esiRecessive(esiRecessive),
  .doRateSwitch(doRateSwitch), .formError(formError), .busIntegrate(busIntegrate),
  .crcInitVector(crcInitVector), .stuffCountInCrc(stuffCountInCrc));

// File: test/cfc_bus_node.sv
// Stand-in for the protocol engine and bus traffic.
// Assumes the bench calls its tasks; all changes follow the falling edge.
`timescale 1ns/1ps
module cfc_bus_node (
  // Clock and abort request
  input wire logic mclk,
  input wire logic abortAllTx,
  // Engine status
  output logic frameActive,
  output logic systemError,
  output logic txAbortDone,
  output logic wakeRequest,
  // Frame fields
  output logic [4:0] fields
);
  int abortLag = 0;
  int waitCnt = 0;
  initial {frameActive, systemError, txAbortDone, wakeRequest, fields} = '0;
  always @(negedge mclk) begin
    waitCnt <= abortAllTx ? waitCnt + 1 : 0;
    txAbortDone <= abortAllTx && waitCnt >= abortLag;
  end
  // Fields change every cycle; inverted after the frame so no stale value lingers
  task automatic frame(input int n);
    @(negedge mclk);
    frameActive <= 1'b1;
    repeat (n) begin
      @(negedge mclk);
      fields <= 5'($urandom);
    end
    frameActive <= 1'b0;
    fields <= ~fields;
  endtask : frame
  task automatic error(input logic v);
    @(negedge mclk);
    systemError <= v;
  endtask : error
  task automatic wake();
    @(negedge mclk);
    wakeRequest <= 1'b1;
    repeat (4) @(negedge mclk);
    wakeRequest <= 1'b0;
  endtask : wake
endmodule : cfc_bus_node

// File: test/tb.sv
// Self-checking bench for the control and bit-timing core.
// Assumes the package is compiled first and the checker is bound.
`timescale 1ns/1ps
module tb;
  logic mclk, rst_n, regWrite, regRead, rdLat, frameActive, systemError, txAbortDone;
  logic wakeRequest, esiRecessive, doRateSwitch, formError, busIntegrate, stuffCountInCrc;
  logic abortAllTx, oscDisable, busy;
  logic [1:0] regIndex;
  logic [31:0] regWdata, regRdata, ctl, expc, nomW, datW, tdcW;
  logic [15:0] crcInitVector;
  logic [2:0] currentMode, tgt;
  logic [3:0] pulses;
  logic [4:0] f;
  cfc_pkg::cfc_options_t options;
  cfc_pkg::cfc_nominal_t nominalTiming;
  cfc_pkg::cfc_data_t dataTiming;
  cfc_pkg::cfc_delay_t delayComp;
  logic [31:0] expQ[$];
  int miscompares = 0;
  int n_checks = 0;
  wire [3:0] obs = {currentMode === tgt, busy, abortAllTx, oscDisable};
  cfc_core dut (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regIndex(regIndex), .regWdata(regWdata), .regRdata(regRdata), .frameActive(frameActive),
    .systemError(systemError), .txAbortDone(txAbortDone), .wakeRequest(wakeRequest),
    .options(options), .nominalTiming(nominalTiming), .dataTiming(dataTiming),
    .delayComp(delayComp), .abortAllTx(abortAllTx), .oscDisable(oscDisable),
    .currentMode(currentMode), .busy(busy), .nominalQuantum(pulses[0]),
    .nominalBit(pulses[1]), .dataQuantum(pulses[2]), .dataBit(pulses[3]), .msgEsi(f[0]),
    .errorPassive(f[1]), .msgRateSwitch(f[2]), .fdfRecessive(f[3]), .resRecessive(f[4]),
    .esiRecessive(esiRecessive), .doRateSwitch(doRateSwitch), .formError(formError),
    .busIntegrate(busIntegrate), .crcInitVector(crcInitVector),
    .stuffCountInCrc(stuffCountInCrc));
  cfc_bus_node node (.mclk(mclk), .abortAllTx(abortAllTx), .frameActive(frameActive),
    .systemError(systemError), .txAbortDone(txAbortDone), .wakeRequest(wakeRequest),
    .fields(f));
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  always @(posedge mclk) rdLat <= regRead;
  always @(negedge mclk) begin
    if (rdLat === 1'b1) chk(regRdata, expQ.pop_front());
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [1:0] i, input logic [31:0] d);
    @(negedge mclk);
    {regWrite, regIndex, regWdata} = {1'b1, i, d};
    @(negedge mclk);
    regWrite = 0;
  endtask : wr
  task automatic rd(input logic [1:0] i, input logic [31:0] e);
    expQ.push_back(e);
    @(negedge mclk);
    {regRead, regIndex} = {1'b1, i};
    @(negedge mclk);
    regRead = 0;
  endtask : rd
  task automatic waitFor(input int s, input logic v);
    int k;
    for (k = 0; k < 60 && obs[s] !== v; k++) @(negedge mclk);
    if (obs[s] !== v) begin
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
    end
  endtask : waitFor
  // Cycles between two pulses of one timing output
  task automatic gap(input int s, input int e);
    int k;
    @(negedge mclk);
    for (k = 0; k < 99 && pulses[s] !== 1'b1; k++) @(negedge mclk);
    for (k = 1; k < 99; k++) begin
      @(negedge mclk);
      if (pulses[s] === 1'b1) break;
    end
    chk(k, e);
    if (k == 99) end_sim();
  endtask : gap
  task automatic comb();
    fork
      node.frame(10);
      repeat (8) begin
        @(posedge mclk);
        chk({busy, esiRecessive, doRateSwitch, formError, busIntegrate,
          stuffCountInCrc, crcInitVector}, {1'b0, ctl[17] ? f[0] | f[1] : f[1], f[2] & ~ctl[12],
          f[3] & f[4] & ctl[6], f[3] & f[4] & ~ctl[6], ctl[5], ctl[5] ? 16'h8000 : 16'h0});
      end
    join
  endtask : comb
  initial begin
    {rst_n, regWrite, regRead, regIndex, regWdata, tgt} = '0;
    void'($urandom(83));
    repeat (12) @(negedge mclk);
    rst_n = 1;
    rd(2'h0, 32'h0498_0760);
    rd(2'h1, 32'h003E_0F0F);
    rd(2'h2, 32'h000E_0303);
    rd(2'h3, 32'h0002_1000);
    $display("test reset values done");
    nomW = 32'h0103_8180 | ($urandom & 32'h7F);
    datW = 32'h02E2_F1F0 | ($urandom & 32'hF);
    tdcW = $urandom;
    wr(2'h1, nomW);
    wr(2'h2, datW);
    wr(2'h3, tdcW);
    rd(2'h1, nomW & 32'hFFFF_7F7F);
    rd(2'h2, datW & 32'hFF1F_0F0F);
    rd(2'h3, tdcW & 32'h0303_7F3F);
    chk(nominalTiming, {nomW[31:16], nomW[14:8], nomW[6:0]});
    chk(dataTiming, {datW[31:24], datW[20:16], datW[11:8], datW[3:0]});
    chk({options.extraIdBitEnable, delayComp}, {tdcW[24], tdcW[17:16], tdcW[14:8], tdcW[5:0]});
    for (int j = 0; j < 2; j++) begin
      ctl = ($urandom & 32'hF01F_1760) | 32'h0400_001F;
      expc = ctl | 32'h0080_0000;
      wr(2'h0, ctl);
      rd(2'h0, expc);
      chk(options, {ctl[20:16], ctl[12], ctl[8], ctl[10:9], ctl[6:5],
        1'b1, 5'h12, tdcW[24], tdcW[25]});
      comb();
    end
    $display("test configuration done");
    for (int m = 0; m < 8; m++) begin
      if (m == 1 || m == 4) continue;
      tgt = 3'(m);
      wr(2'h0, (ctl & 32'hF8FF_FFFF) | (32'(m) << 24));
      waitFor(3, 1'b1);
      tgt = 3'h4;
      wr(2'h0, ctl);
      waitFor(3, 1'b1);
    end
    wr(2'h0, (ctl & 32'hF8FF_FFFF) | 32'h0100_0000);
    waitFor(0, 1'b1);
    chk(currentMode, 3'h4);
    rd(2'h0, (expc & 32'hF8FF_FFFF) | 32'h0100_0000);
    node.wake();
    waitFor(0, 1'b0);
    rd(2'h0, expc);
    $display("test modes done");
    tgt = 3'h0;
    wr(2'h0, ctl & 32'hF8FF_FFFF);
    waitFor(3, 1'b1);
    wr(2'h0, (ctl & 32'hF8FF_FFFF) ^ 32'h001F_017F);
    wr(2'h1, ~nomW);
    rd(2'h0, expc & 32'hF81F_FFFF);
    rd(2'h1, nomW & 32'hFFFF_7F7F);
    gap(0, 2);
    gap(1, 14);
    gap(2, 3);
    gap(3, 18);
    fork
      node.frame(12);
      waitFor(2, 1'b1);
    join
    waitFor(2, 1'b0);
    for (int j = 0; j < 2; j++) begin
      node.abortLag = j ? 0 : 10;
      wr(2'h0, (ctl & 32'hF8FF_FFFF) | 32'h0800_0000);
      if (j == 0) rd(2'h0, expc & 32'hF81F_FFFF | 32'h0800_0000);
      waitFor(1, 1'b0);
    end
    rd(2'h0, expc & 32'hF81F_FFFF);
    tgt = ctl[18] ? 3'h3 : 3'h7;
    node.error(1'b1);
    waitFor(3, 1'b1);
    node.error(1'b0);
    repeat (3) @(negedge mclk);
    tgt = 3'h4;
    wr(2'h0, ctl);
    waitFor(3, 1'b1);
    $display("test normal operation done");
    end_sim();
  end
endmodule : tb
